// ===== core/scan_cfg.svh
// timing-free constants for the scan trigger and common status block
`ifndef SCAN_CFG_SVH
`define SCAN_CFG_SVH

// box that this logic scans for; other boxes only compete for the event input
`define LOCAL_BOX      2'h0
// reset values
`define RST_REPEAT     8'h01
`define RST_CHANNEL    8'h00
// highest save / recall slot
`define SLOT_LAST      4'h9
// standard event register bits
`define ESR_OPC_BIT    0
`define ESR_EXEC_BIT   4
// status byte bits
`define STB_ESB_BIT    5
`define STB_MSS_BIT    6
// fixed answers
`define OPC_ANSWER     8'h01
`define SELFTEST_PASS  8'h00
// saved setup word layout
`define SETUP_BITS     18
`define W_REPEAT       7:0
`define W_SOURCE       9:8
`define W_OUTEN        10
`define W_CONTINUOUS   11
`define W_MODE         13:12
`define W_PORT         17:14

`endif

// ===== core/scan_pkg.sv
// types shared by the scan trigger and common status block
package scan_pkg;

  // trigger source, also the short code returned by the source query
  typedef enum logic [1:0] {
    SRC_BUS,
    SRC_EXTERNAL,
    SRC_HOLD,
    SRC_IMMEDIATE
  } src_e;

  typedef enum logic [4:0] {
    CMD_NOP,
    CMD_SRC_SET,
    CMD_SRC_QUERY,
    CMD_TRIGGER_NOW,
    CMD_START_SCAN,
    CMD_ABORT,
    CMD_SCAN_LIST,
    CMD_REPEAT_SET,
    CMD_CONTINUOUS_SET,
    CMD_OUTEN_SET,
    CMD_MODE_SET,
    CMD_PORT_SET,
    CMD_RESET,
    CMD_TRG,
    CMD_OPC,
    CMD_OPC_QUERY,
    CMD_WAIT,
    CMD_CLS,
    CMD_ESE,
    CMD_ESE_QUERY,
    CMD_ESR_QUERY,
    CMD_SRE,
    CMD_SRE_QUERY,
    CMD_STB_QUERY,
    CMD_SAVE,
    CMD_RECALL,
    CMD_SELFTEST
  } cmd_e;

  typedef enum logic {
    SCAN_IDLE,
    SCAN_RUN
  } scan_state_e;

endpackage

// ===== core/setup_mem.sv
// ten-slot store for saved setups, registered read data
`include "scan_cfg.svh"
module setup_mem (
  input  wire logic                     clk,
  input  wire logic                     wr_en,
  input  wire logic [3:0]               wr_addr,
  input  wire logic [`SETUP_BITS-1:0]   wr_data,
  input  wire logic                     rd_en,
  input  wire logic [3:0]               rd_addr,
  output logic      [`SETUP_BITS-1:0]   rd_data_reg
);
  logic [`SETUP_BITS-1:0] mem [0:9];

  // no reset on the array: slot validity is tracked by the caller
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data_reg <= mem[rd_addr];
    end
  end
endmodule

// ===== core/event_arbiter.sv
// ownership of the shared event input among the switchboxes
module event_arbiter (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_box,
  input  wire logic        req_want,
  output logic             grant,
  output logic             conflict,
  output logic             owned_reg,
  output logic [1:0]       owner_reg
);
  logic mine;

  assign mine     = owned_reg && (owner_reg == req_box);
  // first requester wins; a later one is refused while the owner holds it
  assign grant    = req_valid && req_want && (!owned_reg || mine);
  assign conflict = req_valid && req_want && owned_reg && !mine;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      owned_reg <= 1'b0;
      owner_reg <= 2'h0;
    end else if (grant) begin
      owned_reg <= 1'b1;
      owner_reg <= req_box;
    end else if (req_valid && !req_want && mine) begin
      owned_reg <= 1'b0;
    end
  end

  a_conflict_keeps: assert property (@(posedge clk) disable iff (reset)
    conflict |=> owned_reg && owner_reg == $past(owner_reg))
    else $error("refused request changed the owner");
endmodule

// ===== core/scan_trigger_status.sv
// scan trigger control and common status commands for one switchbox
`include "scan_cfg.svh"

// Function
// - selecting a source only records it; scans start only on start command
// - immediate trigger command advances scan under bus or hold source
// - shared event input has one owner, first box to select it
// - owner keeps event input until it selects another source
// - selecting event input owned by another box raises an error
// - bus source accepts trigger command or group execute trigger
// - trigger command advances only while scanning with bus source
// - start closes first channel; each accepted trigger moves to next
// - source query returns one of four short codes
// - reset opens channels, drops list, repeat 1, immediate, continuous off
// - operation-complete command sets flag and event bit when idle
// - operation-complete query answers 1 once nothing is pending
// - wait command stalls all further commands until nothing pending
// - clear status clears event register and completion request flag
// - event status query returns register and clears it
// - service request mask loads, gates status byte, query returns it
// - event enable mask loads; its query and status byte query are harmless
// - save stores repeat, source, output enable, continuous, mode, port in 0-9
// - recall restores a saved setup from slot 0 to 9
module scan_trigger_status
  import scan_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CMD_VALID,
  output logic             CMD_READY,
  input  wire logic [4:0]  CMD_OP,
  input  wire logic [7:0]  CMD_ARG,
  input  wire logic [1:0]  CMD_BOX,
  input  wire logic        BUS_GET,
  input  wire logic        EVENT_IN,
  input  wire logic        OP_PENDING,
  output logic             RESP_VALID,
  output logic [7:0]       RESP_DATA,
  output logic             ERROR_PULSE,
  output logic [1:0]       TRIGGER_SOURCE,
  output logic [7:0]       REPEAT_COUNT,
  output logic             CONTINUOUS_MODE,
  output logic             TRIGOUT_ENABLE,
  output logic [1:0]       SCAN_MODE,
  output logic [3:0]       SCAN_PORT,
  output logic             SCAN_RUNNING,
  output logic [7:0]       CHANNEL_INDEX,
  output logic             CHANNEL_CLOSED,
  output logic             EVENT_OWNED,
  output logic [1:0]       EVENT_OWNER,
  output logic             SERVICE_REQUEST
);

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  cmd_e                    op;
  logic                    fire;
  logic                    wait_reg;
  logic                    opq_reg;
  logic                    rcl_reg;
  logic                    opc_req_reg;
  logic                    slot_ok;
  logic [9:0]              slot_valid_reg;
  logic [`SETUP_BITS-1:0]  rd_data;
  logic [`SETUP_BITS-1:0]  cur_setup;

  function automatic logic is_cmd(input cmd_e o, input cmd_e want);
    is_cmd = (o == want);
  endfunction

  assign op        = cmd_e'(CMD_OP);
  // stalled while waiting on completion or while a recall reads its slot
  assign CMD_READY = !wait_reg && !opq_reg && !rcl_reg;
  assign fire      = CMD_VALID && CMD_READY;
  assign slot_ok   = CMD_ARG[3:0] <= `SLOT_LAST && CMD_ARG[7:4] == 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // settings
  src_e        src_reg;
  logic [7:0]  repeat_reg;
  logic        cont_reg;
  logic        outen_reg;
  logic [1:0]  mode_reg;
  logic [3:0]  port_reg;
  logic        rst_cmd;
  logic        rcl_apply;

  assign rst_cmd   = fire && is_cmd(op, CMD_RESET);
  assign rcl_apply = rcl_reg;
  assign cur_setup = {port_reg, mode_reg, cont_reg, outen_reg, src_reg, repeat_reg};

  // source requests go through the arbiter: command, recall or reset
  logic        req_valid;
  logic [1:0]  req_box;
  src_e        req_src;
  logic        grant;
  logic        conflict;

  always_comb begin
    req_valid = 1'b0;
    req_box   = `LOCAL_BOX;
    req_src   = SRC_IMMEDIATE;
    if (rst_cmd) begin
      req_valid = 1'b1;
    end else if (rcl_apply) begin
      req_valid = 1'b1;
      req_src   = src_e'(rd_data[`W_SOURCE]);
    end else if (fire && is_cmd(op, CMD_SRC_SET)) begin
      req_valid = 1'b1;
      req_box   = CMD_BOX;
      req_src   = src_e'(CMD_ARG[1:0]);
    end
  end

  event_arbiter u_arb (
    .clk       (CLK),
    .reset     (RESET),
    .req_valid (req_valid),
    .req_box   (req_box),
    .req_want  (req_src == SRC_EXTERNAL),
    .grant     (grant),
    .conflict  (conflict),
    .owned_reg (EVENT_OWNED),
    .owner_reg (EVENT_OWNER)
  );

  // a refused source request leaves the old source in place
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      src_reg <= SRC_IMMEDIATE;
    end else if (req_valid && req_box == `LOCAL_BOX && !conflict) begin
      src_reg <= req_src;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      repeat_reg <= `RST_REPEAT;
      cont_reg   <= 1'b0;
      outen_reg  <= 1'b0;
      mode_reg   <= 2'h0;
      port_reg   <= 4'h0;
    end else if (rst_cmd) begin
      repeat_reg <= `RST_REPEAT;
      cont_reg   <= 1'b0;
    end else if (rcl_apply) begin
      repeat_reg <= rd_data[`W_REPEAT];
      cont_reg   <= rd_data[`W_CONTINUOUS];
      outen_reg  <= rd_data[`W_OUTEN];
      mode_reg   <= rd_data[`W_MODE];
      port_reg   <= rd_data[`W_PORT];
    end else if (fire) begin
      case (op)
        CMD_REPEAT_SET:     repeat_reg <= CMD_ARG;
        CMD_CONTINUOUS_SET: cont_reg   <= CMD_ARG[0];
        CMD_OUTEN_SET:      outen_reg  <= CMD_ARG[0];
        CMD_MODE_SET:       mode_reg   <= CMD_ARG[1:0];
        CMD_PORT_SET:       port_reg   <= CMD_ARG[3:0];
        default:            repeat_reg <= repeat_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // save and recall
  logic sav_cmd;
  logic rcl_cmd;

  assign sav_cmd = fire && is_cmd(op, CMD_SAVE) && slot_ok;
  assign rcl_cmd = fire && is_cmd(op, CMD_RECALL) && slot_ok
                   && slot_valid_reg[CMD_ARG[3:0]];

  setup_mem u_mem (
    .clk         (CLK),
    .wr_en       (sav_cmd),
    .wr_addr     (CMD_ARG[3:0]),
    .wr_data     (cur_setup),
    .rd_en       (rcl_cmd),
    .rd_addr     (CMD_ARG[3:0]),
    .rd_data_reg (rd_data)
  );

  // recall applies one cycle later, once the slot word is out of the store
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rcl_reg        <= 1'b0;
      slot_valid_reg <= 10'h000;
    end else begin
      rcl_reg <= rcl_cmd;
      if (sav_cmd) begin
        slot_valid_reg[CMD_ARG[3:0]] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan engine
  scan_state_e state_reg;
  logic [7:0]  list_len_reg;
  logic [7:0]  chan_reg;
  logic [7:0]  left_reg;
  logic        trig_accept;
  logic        last_chan;

  // only the selected source counts, and only while a scan runs
  always_comb begin
    case (src_reg)
      SRC_BUS:       trig_accept = BUS_GET || (fire && (is_cmd(op, CMD_TRG)
                                   || is_cmd(op, CMD_TRIGGER_NOW)));
      SRC_EXTERNAL:  trig_accept = EVENT_IN && EVENT_OWNED
                                   && EVENT_OWNER == `LOCAL_BOX;
      SRC_HOLD:      trig_accept = fire && is_cmd(op, CMD_TRIGGER_NOW);
      SRC_IMMEDIATE: trig_accept = !OP_PENDING;
      default:       trig_accept = 1'b0;
    endcase
    trig_accept = trig_accept && state_reg == SCAN_RUN;
  end

  assign last_chan = (chan_reg == list_len_reg - 8'h01);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      list_len_reg <= 8'h00;
    end else if (rst_cmd) begin
      list_len_reg <= 8'h00;
    end else if (fire && is_cmd(op, CMD_SCAN_LIST)) begin
      list_len_reg <= CMD_ARG;
    end
  end

  // a repeat count of zero behaves as a single pass
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= SCAN_IDLE;
      chan_reg  <= `RST_CHANNEL;
      left_reg  <= `RST_REPEAT;
    end else if (rst_cmd || (fire && is_cmd(op, CMD_ABORT))) begin
      state_reg <= SCAN_IDLE;
      chan_reg  <= `RST_CHANNEL;
    end else if (fire && is_cmd(op, CMD_START_SCAN) && list_len_reg != 8'h00) begin
      state_reg <= SCAN_RUN;
      chan_reg  <= `RST_CHANNEL;
      left_reg  <= repeat_reg;
    end else if (trig_accept) begin
      if (!last_chan) begin
        chan_reg <= chan_reg + 8'h01;
      end else if (cont_reg || left_reg > 8'h01) begin
        chan_reg <= `RST_CHANNEL;
        left_reg <= cont_reg ? left_reg : left_reg - 8'h01;
      end else begin
        state_reg <= SCAN_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status registers
  logic [7:0] esr_reg;
  logic [7:0] ese_reg;
  logic [7:0] sre_reg;
  logic [7:0] stb;
  logic [7:0] esr_set;
  logic       opc_done;
  logic       bad_slot;

  assign opc_done = opc_req_reg && !OP_PENDING;
  assign bad_slot = fire && (is_cmd(op, CMD_SAVE) || is_cmd(op, CMD_RECALL))
                    && !sav_cmd && !rcl_cmd;
  always_comb begin
    esr_set                = 8'h00;
    esr_set[`ESR_OPC_BIT]  = opc_done;
    esr_set[`ESR_EXEC_BIT] = conflict || bad_slot;
    stb                    = 8'h00;
    stb[`STB_ESB_BIT]      = |(esr_reg & ese_reg);
    stb[`STB_MSS_BIT]      = |(esr_reg & ese_reg) && sre_reg[`STB_ESB_BIT]; // no stb self-read
  end

  assign SERVICE_REQUEST = |(stb & sre_reg);

  // new events win over a read-clear or clear-status in the same cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      esr_reg <= 8'h00;
    end else if (fire && (is_cmd(op, CMD_ESR_QUERY) || is_cmd(op, CMD_CLS))) begin
      esr_reg <= esr_set;
    end else begin
      esr_reg <= esr_reg | esr_set;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ese_reg <= 8'h00;
      sre_reg <= 8'h00;
    end else if (fire && is_cmd(op, CMD_ESE)) begin
      ese_reg <= CMD_ARG;
    end else if (fire && is_cmd(op, CMD_SRE)) begin
      sre_reg <= CMD_ARG;
    end
  end

  // completion tracking for the three completion commands
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      opc_req_reg <= 1'b0;
      opq_reg     <= 1'b0;
      wait_reg    <= 1'b0;
    end else begin
      if (fire && is_cmd(op, CMD_OPC)) begin
        opc_req_reg <= 1'b1;
      end else if (opc_done || (fire && is_cmd(op, CMD_CLS))) begin
        opc_req_reg <= 1'b0;
      end
      opq_reg  <= (fire && is_cmd(op, CMD_OPC_QUERY)) || (opq_reg && OP_PENDING);
      wait_reg <= (fire && is_cmd(op, CMD_WAIT)) || (wait_reg && OP_PENDING);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RESP_VALID <= 1'b0;
      RESP_DATA  <= 8'h00;
    end else begin
      RESP_VALID <= 1'b1;
      if (opq_reg && !OP_PENDING) begin
        RESP_DATA <= `OPC_ANSWER;
      end else if (fire) begin
        case (op)
          CMD_SRC_QUERY: RESP_DATA <= {6'h00, src_reg};
          CMD_ESE_QUERY: RESP_DATA <= ese_reg;
          CMD_ESR_QUERY: RESP_DATA <= esr_reg;
          CMD_SRE_QUERY: RESP_DATA <= sre_reg;
          CMD_STB_QUERY: RESP_DATA <= stb;
          CMD_SELFTEST:  RESP_DATA <= `SELFTEST_PASS;
          default:       RESP_VALID <= 1'b0;
        endcase
      end else begin
        RESP_VALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ERROR_PULSE <= 1'b0;
    end else begin
      ERROR_PULSE <= conflict || bad_slot;
    end
  end

  assign TRIGGER_SOURCE  = src_reg;
  assign REPEAT_COUNT    = repeat_reg;
  assign CONTINUOUS_MODE = cont_reg;
  assign TRIGOUT_ENABLE  = outen_reg;
  assign SCAN_MODE       = mode_reg;
  assign SCAN_PORT       = port_reg;
  assign SCAN_RUNNING    = state_reg == SCAN_RUN;
  assign CHANNEL_INDEX   = chan_reg;
  assign CHANNEL_CLOSED  = state_reg == SCAN_RUN;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_start;
    fire && is_cmd(op, CMD_START_SCAN) && list_len_reg != 8'h00 && !rst_cmd;
  endsequence

  a_start_first: assert property (@(posedge CLK) disable iff (RESET)
    s_start |=> CHANNEL_CLOSED && CHANNEL_INDEX == 8'h00)
    else $error("start did not close first channel");
  a_src_record: assert property (@(posedge CLK) disable iff (RESET)
    fire && is_cmd(op, CMD_SRC_SET) && !SCAN_RUNNING |=> !SCAN_RUNNING)
    else $error("source choice started a scan");
  a_hold_advance: assert property (@(posedge CLK) disable iff (RESET)
    SCAN_RUNNING && src_reg == SRC_HOLD && fire && is_cmd(op, CMD_TRIGGER_NOW)
    && !last_chan |=> CHANNEL_INDEX == $past(CHANNEL_INDEX) + 8'h01)
    else $error("hold trigger did not advance");
  a_trg_bus_only: assert property (@(posedge CLK) disable iff (RESET)
    (src_reg == SRC_HOLD || (src_reg == SRC_EXTERNAL && !EVENT_IN)) && fire
    && is_cmd(op, CMD_TRG)
    |=> $stable(CHANNEL_INDEX))
    else $error("trigger command moved scan off bus source");
  a_idle_ignore: assert property (@(posedge CLK) disable iff (RESET)
    !SCAN_RUNNING && !(fire && is_cmd(op, CMD_START_SCAN)) |=> !SCAN_RUNNING)
    else $error("idle scan woke without start");
  a_conflict_err: assert property (@(posedge CLK) disable iff (RESET)
    conflict |=> ERROR_PULSE && esr_reg[`ESR_EXEC_BIT])
    else $error("conflict not reported");
  a_reset_defaults: assert property (@(posedge CLK) disable iff (RESET)
    rst_cmd |=> src_reg == SRC_IMMEDIATE && REPEAT_COUNT == `RST_REPEAT
    && !CONTINUOUS_MODE && !CHANNEL_CLOSED && list_len_reg == 8'h00)
    else $error("reset defaults wrong");
  a_wait_stall: assert property (@(posedge CLK) disable iff (RESET)
    fire && is_cmd(op, CMD_WAIT) ##1 OP_PENDING |-> !CMD_READY)
    else $error("wait did not stall");
  a_opc_answer: assert property (@(posedge CLK) disable iff (RESET)
    opq_reg && !OP_PENDING |=> RESP_VALID && RESP_DATA == `OPC_ANSWER)
    else $error("completion query answer wrong");
  a_esr_clear: assert property (@(posedge CLK) disable iff (RESET)
    fire && is_cmd(op, CMD_ESR_QUERY) |=> RESP_DATA == $past(esr_reg)
    && esr_reg == $past(esr_set))
    else $error("event status read did not clear");
endmodule

// ===== verif/scan_host.sv
// host controller model issuing commands to the scan block
module scan_host
  import scan_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       ready,
  input  wire logic       rvalid,
  input  wire logic [7:0] rdata,
  output logic            valid,
  output logic      [4:0] op,
  output logic      [7:0] arg,
  output logic      [1:0] box,
  output logic            get,
  output logic            ev,
  output logic            pend
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    valid = 1'b0;
    op = 5'h00;
    arg = 8'h00;
    box = 2'h0;
    get = 1'b0;
    ev = 1'b0;
    pend = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // command held until taken; released op and arg show inverted bits, not stale
  task send(input cmd_e c, input logic [7:0] a, input logic [1:0] b);
    @(posedge clk);
    valid <= 1'b1;
    op <= c;
    arg <= a;
    box <= b;
    @(negedge clk);
    // a stuck stall is left to the bench watchdog, which counts it
    while (ready !== 1'b1) begin
      @(negedge clk);
    end
    @(posedge clk);
    valid <= 1'b0;
    op <= ~c;
    arg <= ~a;
    @(negedge clk);
  endtask

  // query: answer taken on the first cycle it is flagged
  task ask(input cmd_e c, input logic [7:0] a, output logic [7:0] d);
    send(c, a, 2'h0);
    while (rvalid !== 1'b1) begin
      @(negedge clk);
    end
    d = rvalid ? rdata : 8'hxx;
  endtask

  // one-cycle strobe: group execute trigger or shared event input
  task pulse(input logic e);
    @(posedge clk);
    if (e) ev <= 1'b1;
    else get <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    get <= 1'b0;
  endtask

  task hold(input logic v);
    @(posedge clk);
    pend <= v;
  endtask
endmodule

// ===== verif/scan_trigger_status_tb.sv
// self-checking bench for the scan trigger and common status block
module scan_trigger_status_tb;
  import scan_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic valid, ready, rvalid, get, ev, pend, errp, run, closed, owned, cont, outen, srq;
  logic [4:0] op;
  logic [7:0] arg, rdata, rep, idx, d;
  logic [1:0] box, src, mode, owner;
  logic [3:0] port;
  int errors = 0;
  int samples_checked = 0;
  int epulses = 0;
  int e0;

  always #20 CLK = ~CLK;
  // error strobes are counted so their exact cycle does not matter
  always @(posedge CLK) if (errp === 1'b1) epulses++;

  scan_host host (.clk(CLK), .ready(ready), .rvalid(rvalid), .rdata(rdata), .valid(valid),
    .op(op), .arg(arg), .box(box), .get(get), .ev(ev), .pend(pend));

  scan_trigger_status dut (.CLK(CLK), .RESET(RESET), .CMD_VALID(valid), .CMD_READY(ready),
    .CMD_OP(op), .CMD_ARG(arg), .CMD_BOX(box), .BUS_GET(get), .EVENT_IN(ev),
    .OP_PENDING(pend), .RESP_VALID(rvalid), .RESP_DATA(rdata), .ERROR_PULSE(errp),
    .TRIGGER_SOURCE(src), .REPEAT_COUNT(rep), .CONTINUOUS_MODE(cont),
    .TRIGOUT_ENABLE(outen), .SCAN_MODE(mode), .SCAN_PORT(port), .SCAN_RUNNING(run),
    .CHANNEL_INDEX(idx), .CHANNEL_CLOSED(closed), .EVENT_OWNED(owned),
    .EVENT_OWNER(owner), .SERVICE_REQUEST(srq));

  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, seen);
    end
  endtask

  task results;
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task tk(input int n);
    repeat (n) @(negedge CLK);
  endtask

  task sel(input logic [1:0] s, input logic [1:0] b);
    host.send(CMD_SRC_SET, {6'h00, s}, b);
    tk(1);
  endtask

  task cmd(input cmd_e c, input logic [7:0] a);
    host.send(c, a, 2'h0);
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #400000;
    errors++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (9) @(posedge CLK);
    @(negedge CLK);
    chk("src", src, SRC_IMMEDIATE);
    chk("rep", rep, 8'h01);
    chk("cont", cont, 8'h00);
    chk("closed", closed, 8'h00);
    @(posedge CLK);
    RESET <= 1'b0;
    host.ask(CMD_SELFTEST, 8'h00, d);
    chk("tst", d, 8'h00);
    // every source code; only external claims the shared input
    for (int s = 0; s < 4; s++) begin
      sel(s[1:0], 2'h0);
      host.ask(CMD_SRC_QUERY, 8'h00, d);
      chk("srcq", d, 8'(s));
      chk("owned", owned, 8'(s == 1));
      chk("idle", run, 8'h00);
    end
    // second box asking for an owned input is refused
    sel(SRC_EXTERNAL, 2'h0);
    e0 = epulses;
    sel(SRC_EXTERNAL, 2'h1);
    sel(SRC_EXTERNAL, 2'h2);
    tk(2);
    chk("conflict", 8'(epulses - e0), 8'h02);
    chk("owner0", owner, 8'h00);
    sel(SRC_BUS, 2'h0);
    chk("free", owned, 8'h00);
    sel(SRC_EXTERNAL, 2'h1);
    chk("owner1", owner, 8'h01);
    sel(SRC_HOLD, 2'h1);
    // hold source: only the immediate trigger command advances
    cmd(CMD_SCAN_LIST, 8'h03);
    sel(SRC_HOLD, 2'h0);
    cmd(CMD_TRIGGER_NOW, 8'h00);
    tk(1);
    chk("noscan", run, 8'h00);
    cmd(CMD_START_SCAN, 8'h00);
    tk(1);
    chk("ch0", idx, 8'h00);
    chk("closed", closed, 8'h01);
    cmd(CMD_TRG, 8'h00);
    host.pulse(1'b0);
    tk(2);
    chk("trgig", idx, 8'h00);
    cmd(CMD_TRIGGER_NOW, 8'h00);
    tk(1);
    chk("hold1", idx, 8'h01);
    cmd(CMD_TRIGGER_NOW, 8'h00);
    cmd(CMD_TRIGGER_NOW, 8'h00);
    tk(1);
    chk("end", run, 8'h00);
    // bus source: trigger command and group execute trigger both count
    sel(SRC_BUS, 2'h0);
    cmd(CMD_START_SCAN, 8'h00);
    cmd(CMD_TRG, 8'h00);
    tk(1);
    chk("trg", idx, 8'h01);
    host.pulse(1'b0);
    tk(2);
    chk("get", idx, 8'h02);
    host.pulse(1'b1);
    tk(2);
    chk("evig", idx, 8'h02);
    cmd(CMD_TRIGGER_NOW, 8'h00);
    tk(1);
    chk("busend", run, 8'h00);
    // external source advances on the shared input
    sel(SRC_EXTERNAL, 2'h0);
    cmd(CMD_START_SCAN, 8'h00);
    host.pulse(1'b1);
    tk(2);
    chk("ext1", idx, 8'h01);
    cmd(CMD_ABORT, 8'h00);
    sel(SRC_HOLD, 2'h0);
    // completion: flag waits for pending work, wait stalls commands
    host.hold(1'b1);
    cmd(CMD_OPC, 8'h00);
    host.ask(CMD_ESR_QUERY, 8'h00, d);
    chk("opcwait", d, 8'h10);
    cmd(CMD_WAIT, 8'h00);
    tk(2);
    chk("stall", ready, 8'h00);
    host.hold(1'b0);
    tk(2);
    chk("go", ready, 8'h01);
    host.hold(1'b1);
    fork
      host.ask(CMD_OPC_QUERY, 8'h00, d);
      begin
        tk(6);
        chk("early", rvalid, 8'h00);
        host.hold(1'b0);
      end
    join
    chk("opcq", d, 8'h01);
    host.ask(CMD_ESR_QUERY, 8'h00, d);
    chk("esr", d, 8'h01);
    host.ask(CMD_ESR_QUERY, 8'h00, d);
    chk("esrclr", d, 8'h00);
    // masks and the service request summary
    cmd(CMD_ESE, 8'h01);
    cmd(CMD_SRE, 8'h20);
    cmd(CMD_OPC, 8'h00);
    tk(2);
    host.ask(CMD_SRE_QUERY, 8'h00, d);
    chk("sre", d, 8'h20);
    chk("srq", srq, 8'h01);
    for (int i = 0; i < 2; i++) begin
      host.ask(CMD_STB_QUERY, 8'h00, d);
      chk("stb", d, 8'h60);
    end
    host.ask(CMD_ESE_QUERY, 8'h00, d);
    chk("ese", d, 8'h01);
    cmd(CMD_CLS, 8'h00);
    tk(1);
    chk("srqclr", srq, 8'h00);
    host.ask(CMD_ESR_QUERY, 8'h00, d);
    chk("cls", d, 8'h00);
    // save the highest slot, reset, then recall it
    cmd(CMD_REPEAT_SET, 8'h05);
    cmd(CMD_CONTINUOUS_SET, 8'h01);
    cmd(CMD_OUTEN_SET, 8'h01);
    cmd(CMD_MODE_SET, 8'h02);
    cmd(CMD_PORT_SET, 8'h03);
    cmd(CMD_SAVE, 8'h09);
    cmd(CMD_RESET, 8'h00);
    tk(1);
    chk("rstsrc", src, SRC_IMMEDIATE);
    chk("rstrep", rep, 8'h01);
    chk("rstcont", cont, 8'h00);
    cmd(CMD_RECALL, 8'h09);
    tk(2);
    chk("rcrep", rep, 8'h05);
    chk("rcsrc", src, SRC_HOLD);
    chk("rcsetup", {cont, outen, mode, port}, 8'he3);
    e0 = epulses;
    cmd(CMD_SAVE, 8'h0a);
    cmd(CMD_RECALL, 8'h04);
    tk(2);
    chk("slots", 8'(epulses - e0), 8'h02);
    results();
  end
endmodule
